// ---- rtl/ettc_core.sv ----
// Event-triggered transfer controller: descriptor fetch, move, write-back.
// Assumes a memory master port answering with ack; requests from the
// interrupt controller are held until o_act_ack.
// Overview of operation
// - Normal mode moves one item per accepted activation.
// - Repeat mode moves one item, reloads repeat-side address after repeat size.
// - Block mode moves a whole block of 1 to 256 items per activation.
// - Chaining lets one activation walk several descriptors in turn.
// - Short mode uses 24-bit pointers sign-extended from bit 23.
// - Event-link pulse after each item, or each block in block mode.
// - Descriptor is fetched from RAM and written back after transfer.
// - Source mode: 0x fixed, no write-back in full mode, 10 increment, 11 decrement.
// - Destination mode: 0x fixed, no write-back in full mode, 10 increment, 11 decrement.
// - Size 00 byte, 01 word, 10 longword; 11 not programmed.
// - Mode 00 normal, 01 repeat, 10 block; 11 not programmed.
// - Area side 0 makes destination the area, 1 the source.
// - Interrupt every transfer when set, else only on count completion.
// - Chain enable with condition: always, or only on counter 1 to 0/reload.
// - Chained step skips completion check, flag clear and interrupt.
// - Block counter 0 means 65536, decrements after each block.
// - Same vector with read skip set reuses held descriptor.
// - No skip after chain, normal count zero or block count zero.
// - Interrupt after each transfer or after volume.
// - Requests accepted only while start bit set; accepted one finishes.
// - Descriptor address is read from vector base plus 4n.
// - One request at a time; the pending arbiter picks next.
// - In-progress flag set on activation, cleared on completion.
`timescale 1ns/10ps
module ettc_core (
    input wire logic i_ref_clk, // System clock
    input wire logic i_rst, // Async reset, high
    input wire logic [19:0] i_reg_addr, // Register byte address
    input wire logic [31:0] i_reg_wdata, // Register write data
    input wire logic i_reg_wr, // Register write strobe
    input wire logic i_reg_rd, // Register read strobe
    output logic [31:0] o_reg_rdata, // Read data, cycle after strobe
    input wire logic i_act_req, // Highest-priority pending activation
    input wire logic [7:0] i_act_vec, // Its vector number
    output logic o_act_ack, // Request taken
    output logic o_src_clear, // Clear the source flag
    output logic o_route_clear, // Clear source_route_enable
    output logic o_cpu_irq, // Processor interrupt request pulse
    output logic o_event_link, // Event-link pulse
    output logic o_mem_req, // Memory request
    output logic o_mem_we, // Memory write
    output logic [31:0] o_mem_addr, // Memory address
    output logic [1:0] o_mem_size, // 0 byte, 1 word, 2 longword
    output logic [31:0] o_mem_wdata, // Memory write data
    input wire logic i_mem_ack, // Memory answer
    input wire logic [31:0] i_mem_rdata // Memory read data
);
    ettc_pkg::ettc_state_t state;
    logic [7:0] transfer_control;
    logic [31:0] vector_base;
    logic short_mode;
    logic module_start_bit;
    logic in_progress_flag;
    logic [7:0] cur_vec, prev_vec;
    logic prev_valid, no_skip;
    logic [7:0] mode_word_a, mode_word_b;
    logic [31:0] source_pointer, dest_pointer, desc_addr, data_buf;
    logic [15:0] item_counter, block_counter;
    logic [2:0] widx;
    logic chain_now, done_now;
    logic [31:0] link_addr;

    function automatic logic [31:0] ext_ptr(input logic [31:0] p,
                                            input logic s);
        ext_ptr = s ? {{8{p[23]}}, p[23:0]} : p;
    endfunction
    function automatic logic [31:0] step_ptr(input logic [31:0] p,
                                             input logic [1:0] am,
                                             input logic [1:0] sz,
                                             input logic back,
                                             input logic [7:0] n);
        logic [31:0] d;
        d = (sz == ettc_pkg::SZ_BYTE) ? 32'h0000_0001 :
            (sz == ettc_pkg::SZ_WORD) ? 32'h0000_0002 : 32'h0000_0004;
        if (back) d = d - ({23'h00_0000, n == 8'h00, n} << sz);
        if (am == ettc_pkg::AM_INC) step_ptr = p + d;
        else if (am == ettc_pkg::AM_DEC) step_ptr = p - d;
        else step_ptr = p;
    endfunction

    wire [1:0] src_am = mode_word_a[ettc_pkg::MA_SRC_MODE_LSB +: 2];
    wire [1:0] item_size = mode_word_a[ettc_pkg::MA_SIZE_LSB +: 2];
    wire [1:0] xfer_mode = mode_word_a[ettc_pkg::MA_MODE_LSB +: 2];
    wire [1:0] dst_am = mode_word_b[ettc_pkg::MB_DST_MODE_LSB +: 2];
    wire area_side_select = mode_word_b[ettc_pkg::MB_AREA_SIDE_BIT];
    wire irq_every_transfer = mode_word_b[ettc_pkg::MB_IRQ_EVERY_BIT];
    wire chain_condition = mode_word_b[ettc_pkg::MB_CHAIN_COND_BIT];
    wire chain_enable = mode_word_b[ettc_pkg::MB_CHAIN_EN_BIT];
    wire [7:0] reload_size_high = item_counter[15:8];
    wire [7:0] item_low = item_counter[7:0];
    wire is_block = (xfer_mode == ettc_pkg::MD_BLOCK);
    wire is_repeat = (xfer_mode == ettc_pkg::MD_REPEAT);
    wire area_mode = is_block | is_repeat;
    wire last_in_unit = area_mode ? (item_low == 8'h01) : 1'b1;
    wire unit_end = area_mode & last_in_unit;
    wire cnt_to_end = is_block ? (block_counter == 16'h0001) :
                      is_repeat ? (item_low == 8'h01) :
                      (item_counter == 16'h0001);
    wire [2:0] nwords = short_mode ? 3'(ettc_pkg::DESC_WORDS_SHORT) :
                        3'(ettc_pkg::DESC_WORDS_FULL);
    wire src_wb = src_am[1];
    wire dst_wb = dst_am[1];
    wire tc_hit = (i_reg_addr == ettc_pkg::OFF_TRANSFER_CONTROL);
    wire st_ok = i_reg_wr & (i_reg_addr == ettc_pkg::OFF_MODULE_START);

    // Register writes
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            transfer_control <= ettc_pkg::TC_RESET;
            vector_base <= 32'h0000_0000;
            short_mode <= 1'b0;
            module_start_bit <= 1'b0;
        end else if (i_reg_wr) begin
            if (tc_hit) begin
                transfer_control <= (i_reg_wdata[7:0] &
                    8'(1 << ettc_pkg::TC_READ_SKIP_BIT)) |
                    ettc_pkg::TC_FIXED_ONES;
            end
            if (i_reg_addr == ettc_pkg::OFF_VECTOR_BASE)
                vector_base <= i_reg_wdata & ettc_pkg::VBR_MASK;
            if (i_reg_addr == ettc_pkg::OFF_ADDR_MODE)
                short_mode <= i_reg_wdata[0];
            if (st_ok)
                module_start_bit <= i_reg_wdata[0];
        end
    end

    // Register reads; unmapped reads return zero
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 32'h0000_0000;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                ettc_pkg::OFF_TRANSFER_CONTROL:
                    o_reg_rdata <= {24'h00_0000, transfer_control};
                ettc_pkg::OFF_VECTOR_BASE: o_reg_rdata <= vector_base;
                ettc_pkg::OFF_ADDR_MODE:
                    o_reg_rdata <= {31'h0000_0000, short_mode};
                ettc_pkg::OFF_MODULE_START:
                    o_reg_rdata <= {31'h0000_0000, module_start_bit};
                ettc_pkg::OFF_STATUS:
                    o_reg_rdata <= {16'h0000, in_progress_flag, 7'h00,
                                    cur_vec};
                default: o_reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_reg_rdata <= 32'h0000_0000;
        end
    end

    // Chain decision for the current descriptor
    assign chain_now = chain_enable & (~chain_condition | cnt_to_end);
    assign done_now = cnt_to_end & ~chain_now;

    assign o_act_ack = (state == ettc_pkg::ETTC_IDLE) & i_act_req &
                       module_start_bit;
    assign o_mem_req = (state == ettc_pkg::ETTC_VEC_W) |
                       (state == ettc_pkg::ETTC_FETCH_W) |
                       (state == ettc_pkg::ETTC_RD_W) |
                       (state == ettc_pkg::ETTC_WR_W) |
                       (state == ettc_pkg::ETTC_WB_W);
    assign link_addr = vector_base + {22'h00_0000, cur_vec, 2'b00};

    // Sequencer
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ettc_pkg::ETTC_IDLE;
            in_progress_flag <= 1'b0;
            cur_vec <= 8'h00;
            prev_vec <= 8'h00;
            prev_valid <= 1'b0;
            no_skip <= 1'b1;
            mode_word_a <= 8'h00;
            mode_word_b <= 8'h00;
            source_pointer <= 32'h0000_0000;
            dest_pointer <= 32'h0000_0000;
            item_counter <= 16'h0000;
            block_counter <= 16'h0000;
            desc_addr <= 32'h0000_0000;
            data_buf <= 32'h0000_0000;
            widx <= 3'h0;
            o_mem_we <= 1'b0;
            o_mem_addr <= 32'h0000_0000;
            o_mem_size <= 2'h2;
            o_mem_wdata <= 32'h0000_0000;
            o_src_clear <= 1'b0;
            o_route_clear <= 1'b0;
            o_cpu_irq <= 1'b0;
            o_event_link <= 1'b0;
        end else begin
            o_src_clear <= 1'b0;
            o_route_clear <= 1'b0;
            o_cpu_irq <= 1'b0;
            o_event_link <= 1'b0;
            case (state)
                ettc_pkg::ETTC_IDLE: begin
                    if (o_act_ack) begin
                        in_progress_flag <= 1'b1;
                        cur_vec <= i_act_vec;
                        no_skip <= 1'b0;
                        if (prev_valid && i_act_vec == prev_vec && !no_skip &&
                            transfer_control[ettc_pkg::TC_READ_SKIP_BIT]) begin
                            state <= ettc_pkg::ETTC_RD;
                        end else begin
                            state <= ettc_pkg::ETTC_VEC;
                        end
                    end
                end
                ettc_pkg::ETTC_VEC: begin
                    o_mem_we <= 1'b0;
                    o_mem_size <= 2'h2;
                    o_mem_addr <= link_addr;
                    state <= ettc_pkg::ETTC_VEC_W;
                end
                ettc_pkg::ETTC_VEC_W: if (i_mem_ack) begin
                    desc_addr <= ext_ptr(i_mem_rdata, short_mode);
                    widx <= 3'h0;
                    state <= ettc_pkg::ETTC_FETCH;
                end
                ettc_pkg::ETTC_FETCH: begin
                    o_mem_we <= 1'b0;
                    o_mem_size <= 2'h2;
                    o_mem_addr <= desc_addr + {27'h000_0000, widx, 2'b00};
                    state <= ettc_pkg::ETTC_FETCH_W;
                end
                ettc_pkg::ETTC_FETCH_W: if (i_mem_ack) begin
                    case ({short_mode, widx})
                        4'h0: begin
                            mode_word_a <= i_mem_rdata[31:24];
                            mode_word_b <= i_mem_rdata[23:16];
                        end
                        4'h1: source_pointer <= i_mem_rdata;
                        4'h2: dest_pointer <= i_mem_rdata;
                        4'h3, 4'hA: begin
                            item_counter <= i_mem_rdata[31:16];
                            block_counter <= i_mem_rdata[15:0];
                        end
                        4'h8: begin
                            mode_word_a <= i_mem_rdata[31:24];
                            source_pointer <= ext_ptr({8'h00,
                                i_mem_rdata[23:0]}, 1'b1);
                        end
                        4'h9: begin
                            mode_word_b <= i_mem_rdata[31:24];
                            dest_pointer <= ext_ptr(i_mem_rdata, 1'b1);
                        end
                        default: ;
                    endcase
                    widx <= widx + 3'h1;
                    state <= (widx + 3'h1 == nwords) ? ettc_pkg::ETTC_RD :
                             ettc_pkg::ETTC_FETCH;
                end
                ettc_pkg::ETTC_RD: begin
                    o_mem_we <= 1'b0;
                    o_mem_size <= item_size;
                    o_mem_addr <= ext_ptr(source_pointer, short_mode);
                    state <= ettc_pkg::ETTC_RD_W;
                end
                ettc_pkg::ETTC_RD_W: if (i_mem_ack) begin
                    data_buf <= i_mem_rdata;
                    state <= ettc_pkg::ETTC_WR;
                end
                ettc_pkg::ETTC_WR: begin
                    o_mem_we <= 1'b1;
                    o_mem_addr <= ext_ptr(dest_pointer, short_mode);
                    o_mem_wdata <= data_buf;
                    state <= ettc_pkg::ETTC_WR_W;
                end
                ettc_pkg::ETTC_WR_W:
                    if (i_mem_ack) state <= ettc_pkg::ETTC_STEP;
                ettc_pkg::ETTC_STEP: begin
                    // Area side returns to its start at each unit end
                    source_pointer <= step_ptr(source_pointer, src_am,
                        item_size, unit_end & area_side_select,
                        reload_size_high);
                    dest_pointer <= step_ptr(dest_pointer, dst_am,
                        item_size, unit_end & ~area_side_select,
                        reload_size_high);
                    if (area_mode) begin
                        item_counter[7:0] <= last_in_unit ? reload_size_high :
                                             item_low - 8'h01;
                    end else begin
                        item_counter <= item_counter - 16'h0001;
                    end
                    if (is_block && last_in_unit)
                        block_counter <= block_counter - 16'h0001;
                    if (!is_block || last_in_unit)
                        o_event_link <= 1'b1;
                    if (is_block && !last_in_unit) begin
                        state <= ettc_pkg::ETTC_RD;
                    end else begin
                        if (!chain_now && (irq_every_transfer || done_now))
                            o_cpu_irq <= 1'b1;
                        if (done_now) o_route_clear <= 1'b1;
                        if (!chain_now && !done_now && !irq_every_transfer)
                            o_src_clear <= 1'b1;
                        widx <= 3'h0;
                        state <= ettc_pkg::ETTC_WB;
                    end
                end
                ettc_pkg::ETTC_WB: begin
                    o_mem_we <= 1'b1;
                    o_mem_size <= 2'h2;
                    o_mem_addr <= desc_addr + {27'h000_0000, widx, 2'b00};
                    case (widx)
                        3'h0: o_mem_wdata <= short_mode ?
                            {mode_word_a, source_pointer[23:0]} :
                            {mode_word_a, mode_word_b, 16'h0000};
                        3'h1: o_mem_wdata <= short_mode ?
                            {mode_word_b, dest_pointer[23:0]} : source_pointer;
                        3'h2: o_mem_wdata <= short_mode ?
                            {item_counter, block_counter} : dest_pointer;
                        default: o_mem_wdata <= {item_counter, block_counter};
                    endcase
                    // In full mode, fixed pointers skip their write-back
                    if (!short_mode && ((widx == 3'h1 && !src_wb) ||
                        (widx == 3'h2 && !dst_wb))) begin
                        widx <= widx + 3'h1;
                    end else begin
                        state <= ettc_pkg::ETTC_WB_W;
                    end
                end
                ettc_pkg::ETTC_WB_W: if (i_mem_ack) begin
                    o_mem_we <= 1'b0;
                    widx <= widx + 3'h1;
                    state <= (widx + 3'h1 == nwords) ? ettc_pkg::ETTC_NEXT :
                             ettc_pkg::ETTC_WB;
                end
                ettc_pkg::ETTC_NEXT: begin
                    if (chain_now) begin
                        desc_addr <= desc_addr + {27'h000_0000, nwords, 2'b00};
                        no_skip <= 1'b1;
                        widx <= 3'h0;
                        state <= ettc_pkg::ETTC_FETCH;
                    end else begin
                        state <= ettc_pkg::ETTC_DONE;
                    end
                end
                ettc_pkg::ETTC_DONE: begin
                    in_progress_flag <= 1'b0;
                    prev_vec <= cur_vec;
                    prev_valid <= 1'b1;
                    no_skip <= no_skip | chain_enable |
                        (xfer_mode == ettc_pkg::MD_NORMAL &&
                         item_counter == 16'h0000) |
                        (is_block && block_counter == 16'h0000);
                    state <= ettc_pkg::ETTC_IDLE;
                end
                default: state <= ettc_pkg::ETTC_IDLE;
            endcase
        end
    end

    // Checks
    a_accept_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_act_ack |-> module_start_bit)
        else $error("activation accepted while stopped");
    a_one_at_time: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        in_progress_flag |-> !o_act_ack)
        else $error("second activation accepted");
    a_flag_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_act_ack |=> in_progress_flag)
        else $error("in-progress flag not set");
    a_chain_noirq: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ettc_pkg::ETTC_STEP && chain_now && last_in_unit) |=>
        !o_cpu_irq && !o_src_clear && !o_route_clear)
        else $error("chained step raised interrupt");
    a_link_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ettc_pkg::ETTC_STEP && is_block && !last_in_unit)
        |=> !o_event_link)
        else $error("event link inside a block");
    a_short_ext: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ettc_pkg::ETTC_RD_W && short_mode) |->
        o_mem_addr[31:24] == {8{o_mem_addr[23]}})
        else $error("short pointer not sign extended");
    a_block_dec: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ettc_pkg::ETTC_STEP && is_block && last_in_unit) |=>
        block_counter == $past(block_counter) - 16'h0001)
        else $error("block counter not decremented");
    a_vec_addr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ettc_pkg::ETTC_VEC_W) |->
        o_mem_addr == vector_base + {22'h00_0000, cur_vec, 2'b00})
        else $error("wrong vector table address");
    a_normal_one: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state == ettc_pkg::ETTC_STEP && xfer_mode == ettc_pkg::MD_NORMAL)
        |=> state == ettc_pkg::ETTC_WB)
        else $error("normal mode moved more than one item");
    c_chain: cover property (@(posedge i_ref_clk)
        state == ettc_pkg::ETTC_NEXT && chain_now);
    c_skip: cover property (@(posedge i_ref_clk)
        state == ettc_pkg::ETTC_IDLE ##1 state == ettc_pkg::ETTC_RD);
    c_block: cover property (@(posedge i_ref_clk)
        state == ettc_pkg::ETTC_STEP && is_block && last_in_unit);
endmodule

// ---- rtl/ettc_pkg.sv ----
// Package for the event-triggered transfer controller.
// Assumes a single 100 MHz clock domain and a 32-bit word memory bus.
package ettc_pkg;
    // Register byte offsets
    localparam logic [19:0] OFF_TRANSFER_CONTROL = 20'h8_2400;
    localparam logic [19:0] OFF_VECTOR_BASE = 20'h8_2404;
    localparam logic [19:0] OFF_ADDR_MODE = 20'h8_2408;
    localparam logic [19:0] OFF_MODULE_START = 20'h8_240C;
    localparam logic [19:0] OFF_STATUS = 20'h8_240E;
    // transfer_control fields
    localparam int TC_READ_SKIP_BIT = 4;
    localparam logic [7:0] TC_RESET = 8'h08;
    localparam logic [7:0] TC_FIXED_ONES = 8'h08;
    // Status fields
    localparam int ST_IN_PROGRESS_BIT = 15;
    // Mode word A fields
    localparam int MA_SRC_MODE_LSB = 2;
    localparam int MA_SIZE_LSB = 4;
    localparam int MA_MODE_LSB = 6;
    // Mode word B fields
    localparam int MB_DST_MODE_LSB = 2;
    localparam int MB_AREA_SIDE_BIT = 4;
    localparam int MB_IRQ_EVERY_BIT = 5;
    localparam int MB_CHAIN_COND_BIT = 6;
    localparam int MB_CHAIN_EN_BIT = 7;
    // Field codes
    localparam logic [1:0] AM_INC = 2'h2;
    localparam logic [1:0] AM_DEC = 2'h3;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] MD_NORMAL = 2'h0;
    localparam logic [1:0] MD_REPEAT = 2'h1;
    localparam logic [1:0] MD_BLOCK = 2'h2;
    // Descriptor layout, in words
    localparam int DESC_WORDS_FULL = 4;
    localparam int DESC_WORDS_SHORT = 3;
    localparam logic [31:0] VBR_MASK = 32'hFFFF_FC00;
    typedef enum logic [3:0] {
        ETTC_IDLE, ETTC_VEC, ETTC_VEC_W, ETTC_FETCH, ETTC_FETCH_W,
        ETTC_RD, ETTC_RD_W, ETTC_WR, ETTC_WR_W, ETTC_STEP,
        ETTC_WB, ETTC_WB_W, ETTC_NEXT, ETTC_DONE
    } ettc_state_t;
endpackage

// ---- tb/ettc_mem_model.sv ----
// Word memory on the far side of the controller's bus port.
// Assumes one access at a time; i_slow adds two wait cycles.
`timescale 1ns/10ps
module ettc_mem_model (
    input wire logic i_ref_clk, // System clock
    input wire logic i_req, // Access request
    input wire logic i_we, // Write
    input wire logic [31:0] i_addr, // Byte address
    input wire logic [31:0] i_wdata, // Write data
    input wire logic i_slow, // Answer slowly
    output logic o_ack = 1'b0, // Access done
    output logic [31:0] o_rdata = 32'h0000_0000 // Read data with ack
);
    logic [31:0] mem [0:1023];
    logic [1:0] wait_cnt = 2'h0;
    always @(posedge i_ref_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata; // Meaningless outside ack
        if (i_req && !o_ack) begin
            if (wait_cnt == (i_slow ? 2'h2 : 2'h0)) begin
                o_ack <= 1'b1;
                wait_cnt <= 2'h0;
                o_rdata <= mem[i_addr[11:2]];
                if (i_we) begin
                    mem[i_addr[11:2]] <= i_wdata;
                end
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule

// ---- tb/event_triggered_transfer_ctrl_tb.sv ----
// Bench for the transfer controller: registers and two normal moves.
// Assumes the memory model answers every o_mem_req.
`timescale 1ns/10ps
module event_triggered_transfer_ctrl_tb;
    logic i_ref_clk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0;
    logic i_act_req = 0, rd_d = 0, slow = 0;
    logic [19:0] i_reg_addr = 20'h0_0000;
    logic [31:0] i_reg_wdata = 32'h0000_0000, seed = 32'hc549;
    logic [7:0] i_act_vec = 8'h00;
    logic o_act_ack, o_cpu_irq, o_event_link, o_mem_req, o_mem_we, ack;
    logic src_clr, rt_clr;
    logic [1:0] msize;
    logic [31:0] o_reg_rdata, o_mem_addr, o_mem_wdata, rdata;
    logic [63:0] wq[$];
    logic [31:0] rq[$];
    int err_total = 0, num_checks = 0, irqs = 0, links = 0;
    int srcs = 0, routes = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    ettc_core DUT (.i_ref_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
        .i_reg_rd, .o_reg_rdata, .i_act_req, .i_act_vec, .o_act_ack,
        .o_src_clear(src_clr), .o_route_clear(rt_clr), .o_cpu_irq,
        .o_event_link, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata,
        .o_mem_size(msize), .i_mem_ack(ack), .i_mem_rdata(rdata));
    ettc_mem_model u_mem (.i_ref_clk, .i_req(o_mem_req), .i_we(o_mem_we),
        .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_slow(slow),
        .o_ack(ack), .o_rdata(rdata));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        xorshift = s ^ (s << 13);
        xorshift = xorshift ^ (xorshift >> 17);
        xorshift = xorshift ^ (xorshift << 5);
    endfunction
    task automatic chk(input logic ok);
        num_checks++;
        if (!ok) begin
            err_total++;
            $display("ERROR %0t result differs from expected", $time);
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic reg_op(input logic wr, input logic [19:0] a,
                          input logic [31:0] v);
        @(posedge i_ref_clk);
        if (!wr) rq.push_back(v);
        i_reg_addr <= a;
        i_reg_wdata <= v;
        i_reg_wr <= wr;
        i_reg_rd <= !wr;
        @(posedge i_ref_clk);
        i_reg_wr <= 0;
        i_reg_rd <= 0;
    endtask
    // One activation of vector 1; notes item and write-back words
    task automatic activate(input logic [31:0] src, dst, cnt);
        seed = xorshift(seed);
        u_mem.mem[src[11:2]] = seed;
        wq.push_back({dst, seed});
        wq.push_back({32'h0000_0100, 32'h2808_0000});
        wq.push_back({32'h0000_0104, src + 32'h0000_0004});
        wq.push_back({32'h0000_0108, dst + 32'h0000_0004});
        wq.push_back({32'h0000_010C, cnt - 32'h0001_0000});
        @(posedge i_ref_clk);
        i_act_req <= 1;
        i_act_vec <= 8'h01;
        do @(negedge i_ref_clk); while (o_act_ack !== 1'b1);
        @(posedge i_ref_clk);
        i_act_req <= 0;
        for (int k = 0; k < 300 && wq.size() != 0; k++) @(posedge i_ref_clk);
        repeat (4) @(posedge i_ref_clk);
    endtask
    always @(posedge i_ref_clk) begin
        rd_d <= i_reg_rd;
        irqs <= irqs + int'(o_cpu_irq === 1'b1);
        links <= links + int'(o_event_link === 1'b1);
        srcs <= srcs + int'(src_clr === 1'b1);
        routes <= routes + int'(rt_clr === 1'b1);
        if (o_mem_req && ack) chk(msize === 2'h2);
        if (rd_d) chk(o_reg_rdata === rq.pop_front());
        if (o_mem_req && o_mem_we && ack)
            chk({o_mem_addr, o_mem_wdata} === wq.pop_front());
    end
    initial begin
        u_mem.mem[10'h101] = 32'h0000_0100;
        u_mem.mem[10'h040] = 32'h2808_0000;
        u_mem.mem[10'h041] = 32'h0000_0200;
        u_mem.mem[10'h042] = 32'h0000_0300;
        u_mem.mem[10'h043] = 32'h0002_0000;
        repeat (12) @(posedge i_ref_clk);
        i_rst <= 0;
        reg_op(0, ettc_pkg::OFF_TRANSFER_CONTROL, 32'h0000_0008);
        reg_op(1, ettc_pkg::OFF_TRANSFER_CONTROL, 32'h0000_00E7);
        reg_op(0, ettc_pkg::OFF_TRANSFER_CONTROL, 32'h0000_0008);
        reg_op(1, ettc_pkg::OFF_TRANSFER_CONTROL, 32'h0000_0010);
        reg_op(0, ettc_pkg::OFF_TRANSFER_CONTROL, 32'h0000_0018);
        reg_op(0, 20'h8_2500, 32'h0000_0000);
        reg_op(1, ettc_pkg::OFF_VECTOR_BASE, 32'h0000_0400);
        reg_op(1, ettc_pkg::OFF_MODULE_START, 32'h0000_0001);
        activate(32'h0000_0200, 32'h0000_0300, 32'h0002_0000);
        chk(irqs === 0 && links === 1);
        chk(srcs === 1 && routes === 0);
        reg_op(0, ettc_pkg::OFF_STATUS, 32'h0000_0001);
        slow <= 1;
        activate(32'h0000_0204, 32'h0000_0304, 32'h0001_0000);
        chk(irqs === 1 && links === 2);
        chk(srcs === 1 && routes === 1);
        complete_run;
    end
    initial begin
        #50us;
        err_total++;
        complete_run;
    end
endmodule
